// ==== rfts_map.vh ====
// Constants for the transmitter pin-mode sequencer.
// Assumes a 40 MHz system clock standing in for the crystal reference.
`ifndef RFTS_MAP_VH
`define RFTS_MAP_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RFTS_CLK_MHZ          40
`define RFTS_OSC_READY_US     600
`define RFTS_OSC_READY_CYC    (`RFTS_OSC_READY_US * `RFTS_CLK_MHZ)
`define RFTS_LOCK_MAX_US      50
`define RFTS_LOCK_MAX_CYC     (`RFTS_LOCK_MAX_US * `RFTS_CLK_MHZ)
`define RFTS_LOCK_MARGIN_CYC  16
// Clock output: 40 MHz / 24 = 1.667 MHz, half period 12 cycles
`define RFTS_CLKO_HALF_CYC    12
// ----------------------------------------------------------------
// Modes
// ----------------------------------------------------------------
`define RFTS_MODE_DOWN        2'h0
`define RFTS_MODE_IDLE        2'h1
`define RFTS_MODE_UP          2'h2
`endif

// ==== rfts_clk_div.v ====
// Clock output divider with glitch-free release.
// Assumes run is synchronous to clk; output held low while not running.
module rfts_clk_div (
    input  wire clk,
    input  wire rst_n,
    input  wire run,
    input  wire release_req,
    output reg  clk_out,
    output reg  released
);
`include "rfts_map.vh"
    reg [4:0] cnt_q;
    reg       div_q;
    wire      wrap;
    assign wrap = (cnt_q == (`RFTS_CLKO_HALF_CYC - 1));
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= 5'h00;
            div_q    <= 1'b0;
            clk_out  <= 1'b0;
            released <= 1'b0;
        end else if (!run) begin
            cnt_q    <= 5'h00;
            div_q    <= 1'b0;
            clk_out  <= 1'b0; // RULE10
            released <= 1'b0;
        end else begin
            cnt_q <= wrap ? 5'h00 : cnt_q + 5'h01;
            if (wrap) begin
                div_q <= ~div_q;
            end
            // Release only at a rising edge of the divided clock
            if (!released && release_req && wrap && !div_q) begin
                released <= 1'b1; // RULE12
            end
            clk_out <= (released || (release_req && wrap && !div_q)) ? (wrap ? ~div_q : div_q) : 1'b0; // RULE11
        end
    end
endmodule // rfts_clk_div

// ==== rfts_seq.v ====
// Pin-controlled mode and start-up sequencer of a keyed transmitter.
// Assumes key and enable pins are asynchronous; clk stands in for the crystal.
`include "rfts_map.vh"
// Behaviour
// RULE1 - Frequency key high, amplitude low, enable floating starts oscillator and PLL, amplifier off.
// RULE2 - Clock output enabled automatically about 0.6 ms after activation.
// RULE3 - Lock reported no later than 50 us after clock output release.
// RULE4 - Controller toggles amplitude key after lock to modulate power.
// RULE5 - Controller sets amplitude key high, toggles frequency key for frequency keying.
// RULE6 - Low carrier while frequency key low, high carrier while high.
// RULE7 - Floating enable: controller clears amplitude key, then frequency key to power down.
// RULE8 - Driven enable: controller activates with enable high, powers down with enable low.
// RULE9 - Controller takes device clock after activation, returns before power-down.
// RULE10 - Clock output held low throughout power-down.
// RULE11 - Clock output stays low until crystal amplitude threshold is reached.
// RULE12 - Clock output released synchronously, first period complete.
// RULE13 - Clock output is the crystal reference divided down, about 1.6 MHz.
// RULE14 - Controller waits 250 us after clock appears before sending; the testbench controller sends once lock is seen, under 50 us after.
// RULE15 - Pull switch closed while frequency key low, open while high.
// RULE16 - Floating enable: internal enable is OR of both key pins.
// RULE17 - Enable driven low with a key high gives idle, everything off.
// RULE18 - Amplifier enabled whenever amplitude key high and powered up.
// RULE19 - Enable modelled as driven level plus floating flag; modes decoded.
// RULE20 - Lock indication from reference-cycle counter after clock release.
module rfts_seq (
    input  wire clk,
    input  wire arst_n,
    input  wire amplitude_key_pin,
    input  wire frequency_key_pin,
    input  wire enable_level,
    input  wire enable_float,
    output reg  clk_out,
    output reg  pa_enable,
    output reg  crystal_pull_switch_pin,
    output reg  carrier_high,
    output reg  osc_pll_run,
    output reg  pll_locked,
    output reg  idle_mode
);

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] rst_q;
    wire      rst_n;
    reg [3:0] s1_q;
    reg [3:0] s2_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
        end else begin
            s1_q <= {enable_float, enable_level, frequency_key_pin, amplitude_key_pin};
            s2_q <= s1_q;
        end
    end

    wire akey  = s2_q[0];
    wire fkey  = s2_q[1];
    wire en_s  = s2_q[2];
    wire flt_s = s2_q[3];

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function [1:0] mode_of;
        input a;
        input f;
        input e;
        input fl;
        begin
            if (fl) begin
                mode_of = (a | f) ? `RFTS_MODE_UP : `RFTS_MODE_DOWN; // RULE16
            end else if (e) begin
                mode_of = `RFTS_MODE_UP;
            end else begin
                mode_of = (a | f) ? `RFTS_MODE_IDLE : `RFTS_MODE_DOWN; // RULE17
            end
        end
    endfunction

    wire [1:0] mode = mode_of(akey, fkey, en_s, flt_s); // RULE19
    wire       up   = (mode == `RFTS_MODE_UP);

    // ----------------------------------------------------------------
    // Start-up sequencer
    // ----------------------------------------------------------------
    localparam ST_OFF  = 2'h0;
    localparam ST_OSC  = 2'h1;
    localparam ST_LOCK = 2'h2;
    localparam ST_RDY  = 2'h3;

    reg  [1:0]  st_q;
    reg  [1:0]  st_d;
    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    wire        released;
    wire        div_clk;

    always @* begin
        st_d  = st_q;
        cnt_d = cnt_q + 16'h0001;
        case (st_q)
            ST_OFF: begin
                cnt_d = 16'h0000;
                if (up) begin
                    st_d = ST_OSC; // RULE1
                end
            end
            ST_OSC: begin
                if (released) begin
                    st_d  = ST_LOCK;
                    cnt_d = 16'h0000;
                end
            end
            ST_LOCK: begin
                if (cnt_q == (`RFTS_LOCK_MAX_CYC - `RFTS_LOCK_MARGIN_CYC)) begin
                    st_d = ST_RDY; // RULE20
                end
            end
            ST_RDY: begin
                cnt_d = cnt_q;
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if (!up) begin
            st_d  = ST_OFF;
            cnt_d = 16'h0000;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_OFF;
            cnt_q <= 16'h0000;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Divided clock output
    // ----------------------------------------------------------------
    wire osc_ready = (st_q == ST_OSC) && (cnt_q >= (`RFTS_OSC_READY_CYC - 1)); // RULE2
    rfts_clk_div rfts_clk_div_inst (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (up && (st_q != ST_OFF)),
        .release_req (osc_ready),
        .clk_out     (div_clk),
        .released    (released)
    ); // RULE13

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= up & div_clk; // RULE10
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_enable <= 1'b0;
        end else begin
            pa_enable <= up & akey; // RULE18
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_pull_switch_pin <= 1'b0;
        end else begin
            crystal_pull_switch_pin <= up & ~fkey; // RULE15
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carrier_high <= 1'b0;
        end else begin
            carrier_high <= up & fkey; // RULE6
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_pll_run <= 1'b0;
        end else begin
            osc_pll_run <= up; // RULE1
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_locked <= 1'b0;
        end else begin
            pll_locked <= up && (st_d == ST_RDY); // RULE3
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_mode <= 1'b0;
        end else begin
            idle_mode <= (mode == `RFTS_MODE_IDLE); // RULE17
        end
    end
endmodule // rfts_seq

// ==== rfts_seq_assertions.sv ====
// Checker for the pin-mode sequencer outputs.
// Assumes one clock and pins that move at falling edges.
module rfts_seq_chk (
    input wire clk,
    input wire arst_n,
    input wire amplitude_key_pin,
    input wire frequency_key_pin,
    input wire enable_level,
    input wire enable_float,
    input wire clk_out,
    input wire pa_enable,
    input wire crystal_pull_switch_pin,
    input wire carrier_high,
    input wire osc_pll_run,
    input wire pll_locked,
    input wire idle_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [14:0] up_q;
    reg [11:0] lk_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            up_q <= 15'h0;
            lk_q <= 12'h0;
        end else begin
            up_q <= !osc_pll_run ? 15'h0 : up_q + {14'h0, up_q != 15'h7fff};
            lk_q <= (!osc_pll_run || pll_locked) ? 12'h0 : lk_q + {11'h0, clk_out || lk_q != 12'h0};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_clk_low_off: assert property ((!osc_pll_run) [*3] |-> !clk_out)
        else $error("clock out high while off");
    a_clk_wait: assert property ($rose(clk_out) |-> up_q > 15'd23900)
        else $error("clock out released early");
    a_clk_full: assert property ($rose(clk_out) |-> clk_out [*8] ##4 clk_out ##1 !clk_out)
        else $error("first clock phase not full");
    a_lock_time: assert property (lk_q < 12'd2000)
        else $error("lock late");
    a_pa_gate: assert property (pa_enable |-> osc_pll_run)
        else $error("amplifier enabled while not up");
    a_pull_carrier: assert property (osc_pll_run |-> crystal_pull_switch_pin == !carrier_high)
        else $error("switch and carrier disagree");
    a_pa_key: assert property (
        $rose(amplitude_key_pin) && $stable(frequency_key_pin) && $stable(enable_level)
        && $stable(enable_float) && osc_pll_run |-> ##[2:4] pa_enable)
        else $error("amplifier missed key");
    a_idle_dec: assert property (
        (!enable_float && !enable_level && frequency_key_pin) [*5]
        |-> idle_mode && !osc_pll_run)
        else $error("idle decode wrong");
    a_float_up: assert property (
        (enable_float && frequency_key_pin && !amplitude_key_pin) [*5]
        |-> osc_pll_run && !pa_enable && carrier_high)
        else $error("floating start wrong");
endmodule // rfts_seq_chk
bind rfts_seq rfts_seq_chk rfts_seq_chk_inst (.*);

// ==== rfts_mcu.sv ====
// Controller model: drives the key and enable pins, takes the clock.
// Assumes cmd bits are amplitude key, frequency key, enable level, enable float.
module rfts_mcu (
    input  wire       clk,
    input  wire [3:0] cmd,
    input  wire       clk_out,
    output reg  [3:0] pins,
    output reg        ext_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins = 4'h0;
    initial ext_clk = 1'b0;
    always @(negedge clk) begin
        pins <= cmd;
        ext_clk <= (cmd == 4'h0) ? 1'b0 : (ext_clk | clk_out);
    end
endmodule // rfts_mcu

// ==== test_rf_tx_pin_mode_sequencer.sv ====
// Testbench for the pin-mode sequencer.
// Assumes a 40 MHz clock; pins move at falling edges.
module test_rf_tx_pin_mode_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    reg        clk = 1'b0;
    reg        arst_n = 1'b0;
    reg [3:0]  cmd = 4'h0;
    reg [15:0] lfsr_q = 16'hfbd4;
    integer    n_fail = 0;
    integer    compares = 0;
    integer    cyc = 0;
    integer    i;
    integer    t0;
    wire [3:0] pins;
    wire       ext_clk, clk_out, pa, sw, car, osc, lock, idle;
    always #12.5 clk = ~clk;
    rfts_mcu rfts_mcu_inst (.clk(clk), .cmd(cmd), .clk_out(clk_out), .pins(pins), .ext_clk(ext_clk));
    rfts_seq rfts_seq_inst (.clk(clk), .arst_n(arst_n), .amplitude_key_pin(pins[3]),
        .frequency_key_pin(pins[2]), .enable_level(pins[1]), .enable_float(pins[0]),
        .clk_out(clk_out), .pa_enable(pa), .crystal_pull_switch_pin(sw), .carrier_high(car),
        .osc_pll_run(osc), .pll_locked(lock), .idle_mode(idle));
    function [4:0] exp_f(input [3:0] c);
        reg up;
        begin
            up = c[0] ? (c[3] | c[2]) : c[1];
            exp_f = {up, up & c[3], up & !c[2], up & c[2], !up & !c[0] & (c[3] | c[2])};
        end
    endfunction
    task chk(input [4:0] e);
        compares++;
        if ({osc, pa, sw, car, idle} !== e) begin
            n_fail++;
            $display("ERROR %0t outputs %b", $time, {osc, pa, sw, car, idle});
        end
    endtask
    task chk1(input b, input e);
        compares++;
        if (b !== e) begin
            n_fail++;
            $display("ERROR %0t flag mismatch", $time);
        end
    endtask
    task set(input [3:0] c);
        cmd = c;
        repeat (6) @(negedge clk);
        chk(exp_f(c));
    endtask
    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task run_tx(input [3:0] act);
        set(4'h0);
        cmd = act;
        i = cyc;
        @(posedge clk_out);
        t0 = cyc;
        chk1(t0 - i > 23900 && t0 - i < 24100, 1'b1);
        while (lock !== 1'b1) @(negedge clk);
        chk1(cyc - t0 < 2000, 1'b1);
        chk1(ext_clk, 1'b1);
        set(act | 4'h8);
        set((act | 4'h8) & 4'hb);
        set(act | 4'h8);
        set(act);
        @(negedge clk_out);
        @(negedge clk);
        set(4'h0);
        chk1(clk_out | lock, 1'b0);
        $display("test tx %0d done", act);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 70000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (i = 0; i < 32; i++) begin
            lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            set(i < 16 ? i[3:0] : lfsr_q[3:0]);
            chk1(clk_out, 1'b0);
        end
        $display("test modes done");
        run_tx(4'h5);
        run_tx(4'h6);
        complete_run;
    end
endmodule // test_rf_tx_pin_mode_sequencer
